// ---- core/vfu_pkg.sv ----
// package for the vector and floating-point functional unit block
// assumes a single 100 MHz core clock and a plain register port
// Notes on behaviour
// - new element each clock, fixed unit latency
// - element count register sets elements processed
// - operands from vector or scalar, result vector
// - vector add/subtract two's complement, no overflow
// - scalar and vector adders are 64 bits
// - shift single or double element, zero fill
// - full logical: bitwise, merge, compress, mask
// - second logical: bitwise only, enable bit
// - population count, parity is low bit
// - and, or, xor, xnor on 64 bits
// - merge takes first where mask one
// - scalar in scalar out, vector in vector out
// - float add normalizes, checks exponent range
// - full or half multiply, half always rounded
// - multiply normalized only for normalized inputs
// - zero exponents mean integer product, no checks
// - integer product: upper 48 bits, exponent zero
// - integer product sign by sign rules
// - 32-bit product right-justified, upper zero
// - reciprocal assumes top bit one, range checked
// - address units 24 or 32 bits
// - sign 63, biased exponent 62..48, 48-bit fraction
// - overflow forces exponent, flags; underflow zeroes
// - element count register is 7 bits
package vfu_pkg;
   localparam logic [3:0]  REG_ELEM_COUNT = 4'h0;
   localparam logic [3:0]  REG_CTRL       = 4'h4;
   localparam logic [3:0]  REG_STATUS     = 4'h8;
   localparam int          CTRL_SECOND_EN = 0;
   localparam int          CTRL_FP_IE     = 1;
   localparam int          CTRL_WIDE_ADDR = 2;
   localparam int          STAT_BUSY      = 0;
   localparam int          STAT_FP_ERR    = 1;
   localparam int          STAT_REFUSED   = 2;
   localparam logic [2:0]  CTRL_RESET     = 3'h1;
   localparam int          EC_W           = 7;
   localparam logic [14:0] EXP_BIAS       = 15'h4000;
   localparam logic [14:0] EXP_OVF        = 15'h6000;
   localparam logic [14:0] RCP_OVF_MIN    = 15'h6002;
   localparam logic [14:0] RCP_UNF_MAX    = 15'h2001;
   localparam logic [47:0] HALF_MASK      = 48'hffff_fff8_0000;
   localparam logic [95:0] RND_BIT        = 96'h8000_0000_0000;
   localparam int          LAT_ADD        = 3;
   localparam int          LAT_SHIFT      = 4;
   localparam int          LAT_LOGIC      = 2;
   localparam int          LAT_POP        = 5;
   localparam int          LAT_FADD       = 6;
   localparam int          LAT_FMUL       = 7;
   localparam int          LAT_RCP        = 14;
   localparam int          LAT_ADDR       = 2;
   localparam int          LAT_MAX        = 14;
   typedef enum logic [4:0] {
      OP_VADD, OP_VSUB, OP_SHL, OP_SHR, OP_DSHL, OP_DSHR,
      OP_AND, OP_OR, OP_XOR, OP_XNOR, OP_MERGE, OP_CIDX, OP_MTEST,
      OP_POP, OP_PAR, OP_FADD, OP_FSUB, OP_FMUL, OP_FMUL_RND, OP_FMUL_HALF,
      OP_IMUL32, OP_RCP, OP_AADD, OP_AMUL
   } vfu_op_t;
   typedef struct packed {
      vfu_op_t     op;
      logic        scalar_dest;
      logic        scalar_src;
      logic        second_unit;
      logic [6:0]  shift_count;
      logic [63:0] scalar_source_operand;
      logic [63:0] mask;
   } vfu_issue_t;
   typedef struct packed {
      logic [63:0] a;
      logic [63:0] b;
   } vfu_elem_t;
   typedef struct packed {
      logic        valid;
      logic        to_scalar;
      logic [5:0]  index;
      logic [63:0] data;
   } vfu_result_t;
endpackage

// ---- core/vfu_units.sv ----
// vector and floating-point functional units with a register port
// assumes issue logic feeds one element per clock and never overlaps results
`timescale 1ns/10ps
module vfu_units
   import vfu_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   input  wire logic        issue_valid,
   input  wire vfu_issue_t  issue,
   output logic             issue_ready,
   input  wire logic        elem_valid,
   input  wire vfu_elem_t   elem,
   output logic             elem_ready,
   output vfu_result_t      result,
   output logic [63:0]      mask_out,
   output logic             float_error,
   output logic             float_error_interrupt_enable
);
   typedef enum logic {ST_IDLE, ST_RUN} vfu_state_t;

   logic              rst_s1_q;
   logic              rst_n_q;
   vfu_state_t        state_q;
   logic [EC_W-1:0]   element_count_register_q;
   logic [2:0]        ctrl_q;
   logic              fp_err_q;
   logic              refused_q;
   logic [EC_W-1:0]   remain_q;
   logic [5:0]        index_q;
   vfu_issue_t        cur_q;
   logic [63:0]       mask_out_q;
   logic [31:0]       rdata_q;
   vfu_result_t       pipe_q [LAT_MAX];
   logic              pipe_err_q [LAT_MAX];
   logic              issue_take;
   logic              issue_bad;
   logic              accept;
   logic [63:0]       op_a;
   logic [63:0]       op_b;
   logic [63:0]       res;
   logic              res_err;
   logic              res_valid;
   logic [3:0]        lat;
   logic [64:0]       fp_word;

   // reset released through two flops
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rst_s1_q <= 1'b0;
         rst_n_q  <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q  <= rst_s1_q;
      end
   end

   function automatic logic [5:0] vfu_lz(input logic [47:0] v);
      logic [5:0] n;
      logic       f;
      n = 6'h0;
      f = 1'b0;
      for (int i = 47; i >= 0; i--) begin
         if (v[i])
            f = 1'b1;
         else if (!f)
            n = n + 6'h1;
      end
      return n;
   endfunction

   // overflow keeps coefficient, underflow gives all zeros
   function automatic logic [64:0] vfu_range(input logic s, input logic [14:0] e, input logic [47:0] c);
      if (e[14:13] == 2'b11)
         return {1'b1, s, EXP_OVF, c};
      else if (e[14:13] == 2'b00)
         return 65'h0;
      else
         return {1'b0, s, e, c};
   endfunction

   function automatic logic [64:0] vfu_fadd(input logic [63:0] a, input logic [63:0] b, input logic sub);
      logic        sx, sy;
      logic [14:0] ex, ey, diff, e;
      logic [47:0] cx, cy, c;
      logic [48:0] sum;
      logic [5:0]  lz;
      logic        s;
      if (a[62:48] >= b[62:48]) begin
         sx = a[63];
         ex = a[62:48];
         cx = a[47:0];
         sy = b[63] ^ sub;
         ey = b[62:48];
         cy = b[47:0];
      end else begin
         sx = b[63] ^ sub;
         ex = b[62:48];
         cx = b[47:0];
         sy = a[63];
         ey = a[62:48];
         cy = a[47:0];
      end
      diff = ex - ey;
      // bits shifted out are lost, no roundup
      cy = (diff > 15'd47) ? 48'h0 : cy >> diff;
      if (sx == sy) begin
         sum = {1'b0, cx} + {1'b0, cy};
         s = sx;
      end else if (cx >= cy) begin
         sum = {1'b0, cx - cy};
         s = sx;
      end else begin
         sum = {1'b0, cy - cx};
         s = sy;
      end
      if (sum == 49'h0)
         return 65'h0;
      // always normalized, whatever the inputs were
      // exponent pinned at its ends so a wrap never looks in range
      if (sum[48]) begin
         c = sum[48:1];
         e = (ex == 15'h7fff) ? ex : ex + 15'h1;
      end else begin
         lz = vfu_lz(sum[47:0]);
         c = sum[47:0] << lz;
         e = (ex < {9'h0, lz}) ? 15'h0 : ex - {9'h0, lz};
      end
      return vfu_range(s, e, c);
   endfunction

   function automatic logic [64:0] vfu_fmul(input logic [63:0] a, input logic [63:0] b, input vfu_op_t op);
      logic [95:0] p;
      logic [47:0] c;
      logic [14:0] e;
      logic [16:0] ew;
      logic        s;
      s = a[63] ^ b[63];
      p = a[47:0] * b[47:0];
      if (a[62:48] == 15'h0 && b[62:48] == 15'h0)
         return {1'b0, s, 15'h0, p[95:48]};
      if (op != OP_FMUL)
         p = p + RND_BIT;
      ew = {2'b0, a[62:48]} + {2'b0, b[62:48]} - {2'b0, EXP_BIAS};
      c = p[95:48];
      if (a[47] && b[47] && !p[95]) begin
         c = p[94:47];
         ew = ew - 17'h1;
      end
      // wide sum saturates, so below zero underflows and above top overflows
      e = ew[16] ? 15'h0 : (ew[15] ? 15'h7fff : ew[14:0]);
      if (op == OP_FMUL_HALF)
         c = c & HALF_MASK;
      return vfu_range(s, e, c);
   endfunction

   // exact quotient stands in for the table lookup; costly, but bounded
   function automatic logic [64:0] vfu_rcp(input logic [63:0] a);
      logic [95:0] q;
      logic [47:0] c;
      logic [14:0] e;
      c = {1'b1, a[46:0]};
      q = 96'h7fff_ffff_ffff_ffff_ffff_ffff / {48'h0, c};
      e = ~a[62:48] + 15'h2;
      if (e >= RCP_OVF_MIN || a[62:48] <= RCP_UNF_MAX)
         return {1'b1, a[63], EXP_OVF, 1'b0, q[46:0]};
      return {1'b0, a[63], e, q[47:0]};
   endfunction

   function automatic logic [63:0] vfu_logic(input vfu_op_t op, input logic [63:0] a, input logic [63:0] b);
      case (op)
         OP_AND:  return a & b;
         OP_OR:   return a | b;
         OP_XOR:  return a ^ b;
         OP_XNOR: return ~(a ^ b);
         default: return 64'h0;
      endcase
   endfunction

   function automatic logic vfu_bitwise(input vfu_op_t op);
      return op == OP_AND || op == OP_OR || op == OP_XOR || op == OP_XNOR;
   endfunction

   assign issue_bad   = issue.second_unit && (!vfu_bitwise(issue.op) || !ctrl_q[CTRL_SECOND_EN]);
   assign issue_ready = (state_q == ST_IDLE);
   assign issue_take  = issue_valid && issue_ready && !issue_bad;
   assign elem_ready  = (state_q == ST_RUN);
   assign accept      = elem_valid && elem_ready;

   // sequencing over the element count
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q  <= ST_IDLE;
         remain_q <= 7'h0;
         index_q  <= 6'h0;
         cur_q    <= '0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (issue_take) begin
                  cur_q    <= issue;
                  index_q  <= 6'h0;
                  remain_q <= issue.scalar_dest ? 7'h1 : element_count_register_q;
                  if (issue.scalar_dest || element_count_register_q != 7'h0)
                     state_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (accept) begin
                  remain_q <= remain_q - 7'h1;
                  index_q  <= index_q + 6'h1;
                  if (remain_q == 7'h1)
                     state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // scalar may replace the first vector operand
   assign op_a = cur_q.scalar_src ? cur_q.scalar_source_operand : elem.a;
   assign op_b = elem.b;

   always_comb begin
      res       = 64'h0;
      res_err   = 1'b0;
      res_valid = accept;
      lat       = 4'(LAT_LOGIC);
      fp_word   = 65'h0;
      case (cur_q.op)
         OP_VADD: begin
            res = op_a + op_b;
            lat = 4'(LAT_ADD);
         end
         OP_VSUB: begin
            res = op_a + ~op_b + 64'h1;
            lat = 4'(LAT_ADD);
         end
         OP_SHL: begin
            res = (cur_q.shift_count > 7'd63) ? 64'h0 : op_a << cur_q.shift_count;
            lat = 4'(LAT_SHIFT);
         end
         OP_SHR: begin
            res = (cur_q.shift_count > 7'd63) ? 64'h0 : op_a >> cur_q.shift_count;
            lat = 4'(LAT_SHIFT);
         end
         // b carries the next consecutive element
         OP_DSHL: begin
            res = 64'(({op_a, op_b} << cur_q.shift_count) >> 64);
            lat = 4'(LAT_SHIFT);
         end
         OP_DSHR: begin
            res = 64'({op_a, op_b} >> cur_q.shift_count);
            lat = 4'(LAT_SHIFT);
         end
         OP_AND, OP_OR, OP_XOR, OP_XNOR: res = vfu_logic(cur_q.op, op_a, op_b);
         OP_MERGE: res = (op_a & cur_q.mask) | (op_b & ~cur_q.mask);
         // mask high bit belongs to element 0
         OP_CIDX: begin
            res       = {58'h0, index_q};
            res_valid = accept && cur_q.mask[6'd63 - index_q];
         end
         OP_MTEST: res_valid = 1'b0;
         OP_POP: begin
            res = 64'($countones(op_a));
            lat = 4'(LAT_POP);
         end
         OP_PAR: begin
            res = {63'h0, ^op_a};
            lat = 4'(LAT_POP);
         end
         OP_FADD, OP_FSUB: begin
            fp_word = vfu_fadd(op_a, op_b, cur_q.op == OP_FSUB);
            res     = fp_word[63:0];
            res_err = fp_word[64];
            lat     = 4'(LAT_FADD);
         end
         OP_FMUL, OP_FMUL_RND, OP_FMUL_HALF: begin
            fp_word = vfu_fmul(op_a, op_b, cur_q.op);
            res     = fp_word[63:0];
            res_err = fp_word[64];
            lat     = 4'(LAT_FMUL);
         end
         // operands arrive pre-shifted by the requester
         OP_IMUL32: begin
            res = {32'h0, 32'(op_a[62:31] * op_b[47:16])};
            lat = 4'(LAT_FMUL);
         end
         OP_RCP: begin
            fp_word = vfu_rcp(op_a);
            res     = fp_word[63:0];
            res_err = fp_word[64];
            lat     = 4'(LAT_RCP);
         end
         OP_AADD: begin
            res = ctrl_q[CTRL_WIDE_ADDR] ? {32'h0, 32'(op_a + op_b)} : {40'h0, 24'(op_a + op_b)};
            lat = 4'(LAT_ADDR);
         end
         OP_AMUL: begin
            res = ctrl_q[CTRL_WIDE_ADDR] ? {32'h0, 32'(op_a * op_b)} : {40'h0, 24'(op_a * op_b)};
            lat = 4'(LAT_ADDR);
         end
         default: res_valid = 1'b0;
      endcase
   end

   // result enters the line so that it leaves after lat cycles
   generate
      for (genvar i = 0; i < LAT_MAX; i++) begin : g_pipe
         always_ff @(posedge core_clk or negedge rst_n_q) begin
            if (!rst_n_q) begin
               pipe_q[i]     <= '0;
               pipe_err_q[i] <= 1'b0;
            end else if (res_valid && (4'(LAT_MAX) - lat) == 4'(i)) begin
               pipe_q[i]     <= '{valid: 1'b1, to_scalar: cur_q.scalar_dest, index: index_q, data: res};
               pipe_err_q[i] <= res_err;
            end else if (i == 0) begin
               pipe_q[i]     <= '0;
               pipe_err_q[i] <= 1'b0;
            end else begin
               pipe_q[i]     <= pipe_q[i-1];
               pipe_err_q[i] <= pipe_err_q[i-1];
            end
         end
      end
   endgenerate

   assign result = pipe_q[LAT_MAX-1];

   // mask test collects a zero test per element
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q)
         mask_out_q <= 64'h0;
      else if (issue_take && issue.op == OP_MTEST)
         mask_out_q <= 64'h0;
      else if (accept && cur_q.op == OP_MTEST)
         mask_out_q[6'd63 - index_q] <= (op_a == 64'h0);
   end

   assign mask_out = mask_out_q;

   // control registers
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         element_count_register_q <= 7'h0;
         ctrl_q                   <= CTRL_RESET;
      end else if (reg_wr && reg_addr == REG_ELEM_COUNT) begin
         element_count_register_q <= reg_wdata[EC_W-1:0];
      end else if (reg_wr && reg_addr == REG_CTRL) begin
         ctrl_q <= reg_wdata[2:0];
      end
   end

   // sticky flags, write one to clear; a new event wins
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         fp_err_q  <= 1'b0;
         refused_q <= 1'b0;
      end else begin
         if (result.valid && pipe_err_q[LAT_MAX-1])
            fp_err_q <= 1'b1;
         else if (reg_wr && reg_addr == REG_STATUS && reg_wdata[STAT_FP_ERR])
            fp_err_q <= 1'b0;
         if (issue_valid && issue_ready && issue_bad)
            refused_q <= 1'b1;
         else if (reg_wr && reg_addr == REG_STATUS && reg_wdata[STAT_REFUSED])
            refused_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q)
         rdata_q <= 32'h0;
      else if (reg_rd) begin
         case (reg_addr)
            REG_ELEM_COUNT: rdata_q <= {25'h0, element_count_register_q};
            REG_CTRL:       rdata_q <= {29'h0, ctrl_q};
            REG_STATUS:     rdata_q <= {29'h0, refused_q, fp_err_q, state_q == ST_RUN};
            default:        rdata_q <= 32'h0;
         endcase
      end else
         rdata_q <= 32'h0;
   end

   assign reg_rdata                    = rdata_q;
   assign float_error                  = fp_err_q;
   assign float_error_interrupt_enable = ctrl_q[CTRL_FP_IE];
endmodule

// ---- verification/vfu_units_props.sv ----
// checker for the vector and floating-point unit block ports
// assumes one core clock and bench issues only after results drain
`timescale 1ns/10ps
module vfu_units_props
   import vfu_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        rstn,
   input wire logic [3:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        issue_valid,
   input wire vfu_issue_t  issue,
   input wire logic        issue_ready,
   input wire logic        elem_valid,
   input wire vfu_elem_t   elem,
   input wire logic        elem_ready,
   input wire vfu_result_t result
);
   vfu_issue_t iss_q;
   logic [6:0] ec_q;
   logic [6:0] acc_q;
   logic       acc;
   assign acc = elem_valid && elem_ready;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   sequence s_take;
      issue_valid && issue_ready;
   endsequence
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         iss_q <= '0;
         ec_q  <= 7'h0;
         acc_q <= 7'h0;
      end else begin
         if (issue_valid && issue_ready) iss_q <= issue;
         if (reg_wr && reg_addr == REG_ELEM_COUNT) ec_q <= reg_wdata[6:0];
         // count restarts at each take, so one issue is judged alone
         if (issue_valid && issue_ready) acc_q <= 7'h0;
         else if (acc) acc_q <= acc_q + 7'h1;
      end
   end
   a_add_sum: assert property (acc && iss_q.op == OP_VADD |-> ##3 result.valid &&
      result.data == $past(elem.a, 3) + $past(elem.b, 3)) else $error("vector add result wrong");
   a_sub_diff: assert property (acc && iss_q.op == OP_VSUB |-> ##3 result.valid &&
      result.data == $past(elem.a, 3) - $past(elem.b, 3)) else $error("vector subtract result wrong");
   a_xor_bits: assert property (acc && iss_q.op == OP_XOR |-> ##2 result.valid &&
      result.data == ($past(elem.a, 2) ^ $past(elem.b, 2))) else $error("logical result wrong");
   a_shl_fill: assert property (acc && iss_q.op == OP_SHL |-> ##4 result.valid &&
      result.data == ($past(elem.a, 4) << iss_q.shift_count)) else $error("shift result wrong");
   a_pop_count: assert property (acc && iss_q.op == OP_POP |-> ##5 result.valid &&
      result.data == 64'($countones($past(elem.a, 5)))) else $error("population count wrong");
   a_par_bit: assert property (acc && iss_q.op == OP_PAR |-> ##5 result.valid &&
      result.data == {63'h0, ^$past(elem.a, 5)}) else $error("parity result wrong");
   a_mul_latency: assert property (acc && iss_q.op inside {OP_FMUL, OP_IMUL32}
      |-> ##7 result.valid) else $error("multiply latency wrong");
   a_fadd_norm: assert property (acc && iss_q.op inside {OP_FADD, OP_FSUB} |-> ##6 result.valid &&
      (result.data[47] || result.data == 64'h0)) else $error("float add result not normalized");
   sequence s_done;
      $fell(elem_ready);
   endsequence
   a_elem_total: assert property (s_done |-> acc_q == (iss_q.scalar_dest ? 7'h1 : ec_q))
      else $error("element count wrong");
endmodule
bind vfu_units vfu_units_props u_props (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .issue_valid(issue_valid), .issue(issue),
   .issue_ready(issue_ready), .elem_valid(elem_valid), .elem(elem), .elem_ready(elem_ready), .result(result));

// ---- verification/vfu_vreg_model.sv ----
// vector register file model: feeds element pairs, collects results
// assumes bench loads sources and pulses restart with each issue
`timescale 1ns/10ps
module vfu_vreg_model
   import vfu_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        restart,
   input  wire logic        slow,
   input  wire logic        elem_ready,
   input  wire vfu_result_t result,
   output logic             elem_valid,
   output vfu_elem_t        elem
);
   logic [63:0] src_a [64];
   logic [63:0] src_b [64];
   logic [63:0] dst   [64];
   logic [5:0]  idx_q;
   logic        gap_q;
   // operands pre-placed by bench for integer multiply
   assign elem_valid = elem_ready & ~gap_q;
   // idle bus shows inverted data so stale words never look fresh
   assign elem = elem_valid ? {src_a[idx_q], src_b[idx_q]} : ~{src_a[idx_q], src_b[idx_q]};
   // plain always: the bench preloads these arrays directly
   always @(posedge core_clk) begin
      gap_q <= slow & ~gap_q & ~restart;
      if (restart) idx_q <= 6'h0;
      else if (elem_valid) idx_q <= idx_q + 6'h1;
      if (result.valid) dst[result.index] <= result.data;
   end
endmodule

// ---- verification/vector_float_functional_units_bench.sv ----
// testbench for the vector and floating-point unit block
// assumes the vector register model in its own file beside it
`timescale 1ns/10ps
module vector_float_functional_units_bench;
   import vfu_pkg::*;
   localparam logic [63:0] A = 64'haaaa_aaaa_aaaa_aaaa;
   localparam logic [63:0] B = 64'hcccc_cccc_cccc_cccc;
   localparam logic [63:0] S = 64'h5a5a_5a5a_5a5a_5a5a;
   logic        core_clk;
   logic        rstn;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic        issue_valid;
   vfu_issue_t  issue;
   logic        issue_ready;
   logic        elem_valid;
   vfu_elem_t   elem;
   logic        elem_ready;
   vfu_result_t result;
   logic [63:0] mask_out;
   logic        float_error;
   logic        fp_ie;
   logic        restart;
   logic        slow;
   int          error_cnt;
   int          check_count;
   logic [31:0] d;
   vfu_units u_dut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .issue_valid(issue_valid), .issue(issue),
      .issue_ready(issue_ready), .elem_valid(elem_valid), .elem(elem), .elem_ready(elem_ready),
      .result(result), .mask_out(mask_out), .float_error(float_error), .float_error_interrupt_enable(fp_ie));
   vfu_vreg_model u_part (.core_clk(core_clk), .restart(restart), .slow(slow), .elem_ready(elem_ready),
      .result(result), .elem_valid(elem_valid), .elem(elem));
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
      @(posedge core_clk);
   endtask
   task automatic run(input vfu_op_t op, input int n, input logic [63:0] s, m, input logic [6:0] sc,
                      input logic su);
      wr(REG_ELEM_COUNT, 32'(n));
      issue       <= '{op, 1'b0, op == OP_IMUL32, su, sc, s, m};
      issue_valid <= 1'b1;
      restart     <= 1'b1;
      @(posedge core_clk);
      issue_valid <= 1'b0;
      restart     <= 1'b0;
      // stalls can double the feed time, so allow twice the count
      repeat (2 * n + LAT_MAX + 4) @(posedge core_clk);
      chk("idle", 64'h1, 64'(issue_ready));
   endtask
   task automatic run1(input string nm, input vfu_op_t op, input logic [63:0] a, b, s, m,
                       input logic [6:0] sc, input logic su, input logic [63:0] e);
      u_part.src_a[0] = a;
      u_part.src_b[0] = b;
      u_part.dst[0]   = S;
      run(op, 1, s, m, sc, su);
      chk(nm, e, u_part.dst[0]);
   endtask
   task automatic give_verdict();
      if (error_cnt == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      give_verdict();
   end
   initial begin
      rstn = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      issue_valid = 1'b0;
      issue = '0;
      restart = 1'b0;
      slow = 1'b0;
      error_cnt = 0;
      check_count = 0;
      repeat (6) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd(REG_CTRL, d);
      chk("ctrl", 64'h1, 64'(d));
      rd(4'hc, d);
      chk("unmapped", 64'h0, 64'(d));
      wr(REG_ELEM_COUNT, 32'hffff_ffff);
      rd(REG_ELEM_COUNT, d);
      chk("count", 64'h7f, 64'(d));
      for (int i = 0; i < 64; i++) begin
         u_part.src_a[i] = 64'hffff_ffff_ffff_fff0 + 64'(i);
         u_part.src_b[i] = 64'(i * 3) + 64'h11;
      end
      slow <= 1'b1;
      run(OP_VADD, 64, 64'h0, 64'h0, 7'h0, 1'b0);
      slow <= 1'b0;
      for (int i = 0; i < 64; i++) chk("vadd", u_part.src_a[i] + u_part.src_b[i], u_part.dst[i]);
      run(OP_VSUB, 5, 64'h0, 64'h0, 7'h0, 1'b0);
      for (int i = 0; i < 6; i++) chk("vsub", i < 5 ? u_part.src_a[i] - u_part.src_b[i] :
         u_part.src_a[i] + u_part.src_b[i], u_part.dst[i]);
      run1("and", OP_AND, A, B, 0, 0, 0, 0, A & B);
      run1("or", OP_OR, A, B, 0, 0, 0, 0, A | B);
      run1("xor", OP_XOR, A, B, 0, 0, 0, 0, A ^ B);
      run1("xnor", OP_XNOR, A, B, 0, 0, 0, 0, ~(A ^ B));
      run1("merge1", OP_MERGE, A, B, 0, '1, 0, 0, A);
      run1("merge0", OP_MERGE, A, B, 0, 0, 0, 0, B);
      run1("pop", OP_POP, 64'h8000_0000_0000_0007, 0, 0, 0, 0, 0, 64'h4);
      run1("par", OP_PAR, 64'h1_0000_0003, 0, 0, 0, 0, 0, 64'h1);
      run1("shl", OP_SHL, 64'h8000_0000_0000_0001, 0, 0, 0, 7'h4, 0, 64'h10);
      run1("shr", OP_SHR, 64'h8000_0000_0000_0001, 0, 0, 0, 7'h4, 0, 64'h0800_0000_0000_0000);
      run1("shl64", OP_SHL, A, 0, 0, 0, 7'h40, 0, 64'h0);
      run1("dshl", OP_DSHL, 64'h1, 64'hab00_0000_0000_0000, 0, 0, 7'h8, 0, 64'h1ab);
      run1("dshr", OP_DSHR, 64'h1, 64'hab00_0000_0000_0000, 0, 0, 7'h8, 0, 64'h01ab_0000_0000_0000);
      run1("imul", OP_FMUL, 64'h400_0000, 64'h600_0000, 0, 0, 0, 0, 64'h18);
      run1("imulneg", OP_FMUL, 64'h8000_0000_0400_0000, 64'h600_0000, 0, 0, 0, 0, 64'h8000_0000_0000_0018);
      run1("imul32", OP_IMUL32, 64'h2_8000_0000, 64'h7_0000, 64'h2_8000_0000, 0, 0, 0, 64'h23);
      run1("imul32w", OP_IMUL32, 64'h7fff_ffff_8000_0000, 64'h2_0000, 64'h7fff_ffff_8000_0000, 0, 0, 0,
           64'hffff_fffe);
      run1("fadd", OP_FADD, 64'h4030_0000_0000_0005, 0, 0, 0, 0, 0, 64'h4003_a000_0000_0000);
      chk("fperr0", 64'h0, 64'(float_error));
      run1("fmulunf", OP_FMUL, 64'h2000_8000_0000_0000, 64'h2000_8000_0000_0000, 0, 0, 0, 0, 0);
      chk("fperr1", 64'h0, 64'(float_error));
      run1("fmulovf", OP_FMUL, 64'h5800_8000_0000_0000, 64'h5800_8000_0000_0000, 0, 0, 0, 0,
           64'h6000_8000_0000_0000);
      chk("fperr2", 64'h1, 64'(float_error));
      wr(REG_STATUS, 32'h2);
      rd(REG_STATUS, d);
      chk("fpclr", 64'h0, 64'(d & 32'h2));
      wr(REG_CTRL, 32'h2);
      @(posedge core_clk);
      chk("ie", 64'h1, 64'(fp_ie));
      run1("second_off", OP_AND, A, B, 0, 0, 0, 1, S);
      rd(REG_STATUS, d);
      chk("refused", 64'h4, 64'(d & 32'h4));
      wr(REG_STATUS, 32'h4);
      wr(REG_CTRL, 32'h1);
      run1("second_and", OP_AND, A, B, 0, 0, 0, 1, A & B);
      rd(REG_STATUS, d);
      chk("norefuse", 64'h0, 64'(d & 32'h4));
      run1("second_merge", OP_MERGE, A, B, 0, '1, 0, 1, S);
      rd(REG_STATUS, d);
      chk("refused2", 64'h4, 64'(d & 32'h4));
      run1("mtest", OP_MTEST, 0, 0, 0, 0, 0, 0, S);
      chk("mask", 64'h8000_0000_0000_0000, mask_out);
      run1("cidx", OP_CIDX, A, B, 0, 64'h8000_0000_0000_0000, 0, 0, 0);
      run1("aadd", OP_AADD, 64'h1_00ff_ffff, 64'h2, 0, 0, 0, 0, 64'h1);
      give_verdict();
   end
endmodule
